// ---- tx_buf_device.sv ----
// Device end: unpacks command words, strips offsets and filler, and feeds bytes to the MAC.
//
// Overview of operation
// - Command A offset field gives first byte position.
// - Command A first-segment bit starts a packet.
// - Command A last-segment bit ends the packet.
// - Sum buffer counts, mismatch sets transmit error.
// - Count plus alignment gives filler DWORD count.
// - Command B tag copied into packet status.
// - Command B bit 13 suppresses CRC append unless bit 12 is set.
// - Command B bit 12 suppresses padding, CRC kept.
// - Host gives packet length; mismatch flags error.
// - Command A, command B, then data follow.
// - Low offset bits select first byte lane.
// - Upper offset bits skip whole DWORDs, discarded.
// - Unused trailing bytes never reach the MAC.
// - Per-buffer end alignment; filler stripped by device.
// - Host writes zero to reserved fields.
// - Interrupt-on-completion bit pulses buffer loaded flag.
// - Alignment codes 4, 16, 32 bytes, 11 reserved.
// - Middle buffers at least four bytes long.
// - Store command A always, B on first.
`timescale 1ns/1ps
`include "tx_unpack_cfg.svh"
module tx_buf_device
    import tx_unpack_pkg::*;
(
    tx_link_if.dev_end link,
    input wire logic mac_ready,
    output logic mac_valid,
    output logic [7:0] mac_data,
    output logic mac_last,
    output logic cmd_store_valid,
    output logic [31:0] cmd_store_word,
    output logic pkt_done,
    output logic [15:0] pkt_tag,
    output logic pkt_add_crc,
    output logic pkt_add_pad,
    output logic pkt_error,
    input wire logic error_clear,
    output logic transmit_error_flag,
    output logic buffer_loaded_flag
);

    dev_reg_t r;
    dev_reg_t next_r;
    logic advance;
    logic take;
    logic route;
    logic finish;
    logic err_set;
    logic [4:0] ofs;
    logic [10:0] len;
    logic [11:0] bytes_up;
    logic [9:0] data_dws;
    logic [9:0] total_dws;
    logic [9:0] neg_dws;
    logic [2:0] pad_mask;

    // ----------------------------------------------------------------------
    // Buffer length arithmetic
    // ----------------------------------------------------------------------
    // The filler DWORD count is worked out once, when command B arrives, so the
    // data path never has to do wide arithmetic per byte.
    always_comb begin
        ofs = r.cmd_a[`A_OFS_HI:`A_OFS_LO];
        len = r.cmd_a[`LEN_HI:0];
        bytes_up = {10'h000, ofs[1:0]} + {1'b0, len} + `ROUND_UP_BYTES;
        data_dws = bytes_up[11:2];
        total_dws = {7'h00, ofs[4:2]} + data_dws;
        neg_dws = ~total_dws + 10'h001;
        // The reserved code falls back to plain DWORD alignment: no filler expected.
        case (r.cmd_a[`A_ALIGN_HI:`A_ALIGN_LO])
            `ALIGN_16: pad_mask = `PADMASK_16;
            `ALIGN_32: pad_mask = `PADMASK_32;
            default: pad_mask = `PADMASK_4;
        endcase
    end

    // ----------------------------------------------------------------------
    // Unpacking state machine
    // ----------------------------------------------------------------------
    always_comb begin
        next_r = r;
        take = 1'b0;
        route = 1'b0;
        finish = 1'b0;
        err_set = 1'b0;
        advance = !r.mac_valid || mac_ready;
        next_r.pkt_done = 1'b0;
        next_r.buffer_loaded_flag = 1'b0;
        next_r.cmd_store_valid = 1'b0;
        if (advance) begin
            next_r.mac_valid = 1'b0;
            next_r.mac_last = 1'b0;
        end
        case (r.state)
            dev_wait_a: begin
                take = 1'b1;
                if (link.link_valid) begin
                    next_r.cmd_a = link.link_data;
                    next_r.cmd_store_valid = 1'b1;
                    next_r.cmd_store_word = link.link_data;
                    next_r.state = dev_wait_b;
                end
            end
            dev_wait_b: begin
                take = 1'b1;
                if (link.link_valid) begin
                    next_r.skip = ofs[4:2];
                    next_r.lane = ofs[1:0];
                    next_r.rem = len;
                    next_r.pad = neg_dws[2:0] & pad_mask;
                    next_r.have = 1'b0;
                    if (r.cmd_a[`A_FIRST_BIT]) begin
                        next_r.cmd_store_valid = 1'b1;
                        next_r.cmd_store_word = link.link_data;
                        next_r.sum = {1'b0, len};
                        next_r.pkt_len = link.link_data[`LEN_HI:0];
                        next_r.pkt_tag = link.link_data[`B_TAG_HI:`B_TAG_LO];
                        // Disabling padding forces the CRC back on.
                        next_r.pkt_add_crc = !link.link_data[`B_NOCRC_BIT]
                            || link.link_data[`B_NOPAD_BIT];
                        next_r.pkt_add_pad = !link.link_data[`B_NOPAD_BIT];
                    end else begin
                        next_r.sum = r.sum + {1'b0, len};
                    end
                    route = 1'b1;
                end
            end
            dev_skip: begin
                take = 1'b1;
                if (link.link_valid) begin
                    next_r.skip = r.skip - 3'h1;
                    route = (r.skip == 3'h1);
                end
            end
            dev_data: begin
                if (!r.have) begin
                    take = 1'b1;
                    if (link.link_valid) begin
                        next_r.word = link.link_data;
                        next_r.have = 1'b1;
                    end
                end else if (advance) begin
                    next_r.mac_valid = 1'b1;
                    next_r.mac_data = r.word[{r.lane, 3'b000} +: 8];
                    next_r.mac_last = r.cmd_a[`A_LAST_BIT] && (r.rem == 11'h001);
                    next_r.rem = r.rem - 11'h001;
                    next_r.lane = r.lane + 2'h1;
                    // Lanes past the count are dropped with the word.
                    if (r.lane == `LAST_LANE || r.rem == 11'h001) begin
                        next_r.have = 1'b0;
                    end
                    route = (r.rem == 11'h001);
                end
            end
            dev_pad: begin
                take = 1'b1;
                if (link.link_valid) begin
                    next_r.pad = r.pad - 3'h1;
                    finish = (r.pad == 3'h1);
                end
            end
            default: begin
                next_r.state = dev_wait_a;
            end
        endcase
        // Pick the next phase of the buffer from what is still outstanding.
        if (route) begin
            if (next_r.skip != 3'h0) begin
                next_r.state = dev_skip;
            end else if (next_r.rem != 11'h000) begin
                next_r.state = dev_data;
            end else if (next_r.pad != 3'h0) begin
                next_r.state = dev_pad;
            end else begin
                finish = 1'b1;
            end
        end
        // Buffer complete: report loading and close the packet on its last segment.
        if (finish) begin
            next_r.state = dev_wait_a;
            next_r.buffer_loaded_flag = r.cmd_a[`A_IOC_BIT];
            if (r.cmd_a[`A_LAST_BIT]) begin
                // A single-buffer packet can finish in the cycle that takes command B.
                err_set = (next_r.sum != {1'b0, next_r.pkt_len});
                next_r.pkt_done = 1'b1;
                next_r.pkt_error = err_set;
            end
        end
        // A mismatch in the same cycle as a clear still leaves the flag set.
        next_r.transmit_error_flag = (r.transmit_error_flag && !error_clear) || err_set;
        link.link_ready = take;
    end

    // State register.
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state flops.
    assign mac_valid = r.mac_valid;
    assign mac_data = r.mac_data;
    assign mac_last = r.mac_last;
    assign cmd_store_valid = r.cmd_store_valid;
    assign cmd_store_word = r.cmd_store_word;
    assign pkt_done = r.pkt_done;
    assign pkt_tag = r.pkt_tag;
    assign pkt_add_crc = r.pkt_add_crc;
    assign pkt_add_pad = r.pkt_add_pad;
    assign pkt_error = r.pkt_error;
    assign transmit_error_flag = r.transmit_error_flag;
    assign buffer_loaded_flag = r.buffer_loaded_flag;

endmodule // tx_buf_device

// ---- tx_unpack_cfg.svh ----
// Field positions, encodings and register offsets shared by both ends of the transmit link.
`ifndef TX_UNPACK_CFG_SVH
`define TX_UNPACK_CFG_SVH

// ----------------------------------------------------------------------
// Command word A fields
// ----------------------------------------------------------------------
`define A_IOC_BIT 31
`define A_ALIGN_HI 25
`define A_ALIGN_LO 24
`define A_OFS_HI 20
`define A_OFS_LO 16
`define A_FIRST_BIT 13
`define A_LAST_BIT 12
`define A_RSVD_MASK 32'h7ce0_c800

// ----------------------------------------------------------------------
// Command word B fields
// ----------------------------------------------------------------------
`define B_TAG_HI 31
`define B_TAG_LO 16
`define B_NOCRC_BIT 13
`define B_NOPAD_BIT 12
`define B_RSVD_MASK 32'h0000_c800

// Eleven-bit byte count, low bits of both command words.
`define LEN_HI 10

// ----------------------------------------------------------------------
// End alignment codes and padding masks in DWORDs
// ----------------------------------------------------------------------
`define ALIGN_16 2'b01
`define ALIGN_32 2'b10
`define PADMASK_4 3'h0
`define PADMASK_16 3'h3
`define PADMASK_32 3'h7
`define LAST_LANE 2'h3
`define ROUND_UP_BYTES 12'h003
`define MIN_MIDDLE_LEN 11'h004

// ----------------------------------------------------------------------
// Host controller APB register offsets and status fields
// ----------------------------------------------------------------------
`define REG_CMD_A 12'h000
`define REG_CMD_B 12'h004
`define REG_SEND 12'h008
`define REG_DATA 12'h00c
`define REG_STATUS 12'h010
`define STAT_BUSY_BIT 0

`endif

// ---- tx_unpack_pkg.sv ----
// Types shared by the transmit buffer host end and device end.
package tx_unpack_pkg;

    // ----------------------------------------------------------------------
    // Device end
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        dev_wait_a = 3'b000,
        dev_wait_b = 3'b001,
        dev_skip = 3'b011,
        dev_data = 3'b010,
        dev_pad = 3'b110
    } dev_state_t;

    typedef struct packed {
        dev_state_t state;
        logic [31:0] cmd_a;
        logic [31:0] word;
        logic have;
        logic [1:0] lane;
        logic [10:0] rem;
        logic [2:0] skip;
        logic [2:0] pad;
        logic [11:0] sum;
        logic [10:0] pkt_len;
        logic [15:0] pkt_tag;
        logic pkt_add_crc;
        logic pkt_add_pad;
        logic pkt_error;
        logic pkt_done;
        logic transmit_error_flag;
        logic buffer_loaded_flag;
        logic cmd_store_valid;
        logic [31:0] cmd_store_word;
        logic mac_valid;
        logic [7:0] mac_data;
        logic mac_last;
    } dev_reg_t;

    // ----------------------------------------------------------------------
    // Host end
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        host_idle = 3'b000,
        host_send_a = 3'b001,
        host_send_b = 3'b011,
        host_done = 3'b010,
        host_data = 3'b110
    } host_state_t;

    typedef struct packed {
        host_state_t state;
        logic [31:0] cmd_a;
        logic [31:0] cmd_b;
        logic [31:0] out_word;
        logic [15:0] words_sent;
    } host_reg_t;

endpackage

// ---- tx_link_if.sv ----
// Word link that carries transmit buffers from the host end to the device end.
`timescale 1ns/1ps
interface tx_link_if (
    input logic pclk,
    input logic presetn
);
    logic link_valid;
    logic link_ready;
    logic [31:0] link_data;

    modport host_end (
        input pclk,
        input presetn,
        output link_valid,
        output link_data,
        input link_ready
    );

    modport dev_end (
        input pclk,
        input presetn,
        input link_valid,
        input link_data,
        output link_ready
    );
endinterface

// ---- tx_buf_host.sv ----
// Host end: APB-programmed controller that writes command words and data onto the link.
`timescale 1ns/1ps
`include "tx_unpack_cfg.svh"
module tx_buf_host
    import tx_unpack_pkg::*;
(
    tx_link_if.host_end link,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    host_reg_t r;
    host_reg_t next_r;
    logic access;
    logic mid_short;

    // ----------------------------------------------------------------------
    // Register decode and link sequencing
    // ----------------------------------------------------------------------
    // Writes to SEND and DATA hold pready low until the link has taken the words,
    // so software back-pressure comes straight from the device.
    always_comb begin
        next_r = r;
        access = psel && penable;
        pready = 1'b0;
        pslverr = 1'b0;
        prdata = 32'h0000_0000;
        mid_short = !r.cmd_a[`A_FIRST_BIT] && !r.cmd_a[`A_LAST_BIT]
            && (r.cmd_a[`LEN_HI:0] < `MIN_MIDDLE_LEN);
        link.link_valid = (r.state == host_send_a) || (r.state == host_send_b)
            || (r.state == host_data);
        link.link_data = r.out_word;
        case (r.state)
            host_idle: begin
                if (access && pwrite && paddr == `REG_SEND && !mid_short) begin
                    next_r.out_word = r.cmd_a;
                    next_r.state = host_send_a;
                end else if (access && pwrite && paddr == `REG_DATA) begin
                    next_r.out_word = pwdata;
                    next_r.state = host_data;
                end else if (access) begin
                    pready = 1'b1;
                    case (paddr)
                        `REG_CMD_A: begin
                            prdata = r.cmd_a;
                            if (pwrite) begin
                                next_r.cmd_a = pwdata & ~`A_RSVD_MASK;
                            end
                        end
                        `REG_CMD_B: begin
                            prdata = r.cmd_b;
                            if (pwrite) begin
                                next_r.cmd_b = pwdata & ~`B_RSVD_MASK;
                            end
                        end
                        `REG_SEND: begin
                            pslverr = pwrite;
                        end
                        `REG_STATUS: begin
                            prdata = {r.words_sent, 16'h0000};
                            pslverr = pwrite;
                        end
                        default: begin
                            pslverr = 1'b1;
                        end
                    endcase
                end
            end
            host_send_a: begin
                if (link.link_ready) begin
                    next_r.out_word = r.cmd_b;
                    next_r.words_sent = r.words_sent + 16'h0001;
                    next_r.state = host_send_b;
                end
            end
            host_send_b: begin
                if (link.link_ready) begin
                    next_r.words_sent = r.words_sent + 16'h0001;
                    next_r.state = host_done;
                end
            end
            host_data: begin
                if (link.link_ready) begin
                    next_r.words_sent = r.words_sent + 16'h0001;
                    next_r.state = host_done;
                end
            end
            host_done: begin
                pready = 1'b1;
                next_r.state = host_idle;
            end
            default: begin
                next_r.state = host_idle;
            end
        endcase
        if (r.state != host_idle) begin
            prdata[`STAT_BUSY_BIT] = (paddr == `REG_STATUS);
        end
    end

    // State register.
    always_ff @(posedge link.pclk or negedge link.presetn) begin
        if (!link.presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule // tx_buf_host

// ---- tx_unpack_checker.sv ----
// Concurrent checks on the transmit link and the device end's MAC and flag outputs.
`timescale 1ns/1ps
module tx_unpack_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_valid,
    input wire logic link_ready,
    input wire logic [31:0] link_data,
    input wire logic mac_ready,
    input wire logic mac_valid,
    input wire logic [7:0] mac_data,
    input wire logic mac_last,
    input wire logic cmd_store_valid,
    input wire logic [31:0] cmd_store_word,
    input wire logic pkt_done,
    input wire logic pkt_error,
    input wire logic error_clear,
    input wire logic transmit_error_flag,
    input wire logic buffer_loaded_flag
);
    // ----------------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A word offered but not taken must not change under the device.
    property p_link_hold;
        link_valid && !link_ready |=> link_valid && $stable(link_data);
    endproperty
    a_link_hold: assert property (p_link_hold) else $error("link word changed before taken");

    // A byte stalled by the MAC stays put with its end marker.
    property p_mac_hold;
        mac_valid && !mac_ready |=> mac_valid && $stable(mac_data) && $stable(mac_last);
    endproperty
    a_mac_hold: assert property (p_mac_hold) else $error("mac byte changed while stalled");

    // Every stored command word is a word just taken off the link.
    property p_store_take;
        cmd_store_valid |-> $past(link_valid && link_ready) && cmd_store_word == $past(link_data);
    endproperty
    a_store_take: assert property (p_store_take) else $error("stored word not from link");

    // A bad packet raises the sticky error at once.
    property p_err_set;
        pkt_done && pkt_error |-> transmit_error_flag;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error flag not raised");

    // The error flag only falls when cleared.
    property p_err_sticky;
        transmit_error_flag && !error_clear |=> transmit_error_flag;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");

    // Clearing wins unless a new bad packet lands at the same edge.
    property p_err_clear;
        error_clear |=> !transmit_error_flag || (pkt_done && pkt_error);
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

    // The loaded flag is a single pulse per buffer.
    property p_loaded_pulse;
        buffer_loaded_flag |=> !buffer_loaded_flag;
    endproperty
    a_loaded_pulse: assert property (p_loaded_pulse) else $error("loaded flag too long");

    // After the closing byte, the next buffer needs two command words first.
    property p_last_gap;
        mac_valid && mac_ready && mac_last |=> !mac_valid [*2];
    endproperty
    a_last_gap: assert property (p_last_gap) else $error("byte right after packet end");

    c_done: cover property (pkt_done);
    c_error: cover property (pkt_done && pkt_error);
    c_stall: cover property (mac_valid && !mac_ready);
endmodule // tx_unpack_checker

// ---- tx_buffer_command_unpacker_tb.sv ----
// Testbench that joins both ends and drives the host end over APB.
`timescale 1ns/1ps
`include "tx_unpack_cfg.svh"
module tx_buffer_command_unpacker_tb;
    import tx_unpack_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mac_ready = 0, error_clear = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, cmd_store_word, rd;
    logic pready, pslverr, mac_valid, mac_last, cmd_store_valid, pkt_done, e;
    logic pkt_add_crc, pkt_add_pad, pkt_error, transmit_error_flag, buffer_loaded_flag;
    logic [7:0] mac_data;
    logic [15:0] pkt_tag;
    logic [18:0] st;
    logic [1:0] cyc = '0;
    logic [8:0] exp_q[$];
    int num_errors = 0, check_count = 0, dones = 0, loads = 0, stores = 0, n_ld = 0, n_st = 0;
    int words = 0;

    tx_link_if tx_link_if_i (.pclk(pclk), .presetn(presetn));
    tx_buf_host tx_buf_host_i (.link(tx_link_if_i), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    tx_buf_device tx_buf_device_i (.link(tx_link_if_i), .mac_ready(mac_ready),
        .mac_valid(mac_valid), .mac_data(mac_data), .mac_last(mac_last),
        .cmd_store_valid(cmd_store_valid), .cmd_store_word(cmd_store_word),
        .pkt_done(pkt_done), .pkt_tag(pkt_tag), .pkt_add_crc(pkt_add_crc),
        .pkt_add_pad(pkt_add_pad), .pkt_error(pkt_error), .error_clear(error_clear),
        .transmit_error_flag(transmit_error_flag), .buffer_loaded_flag(buffer_loaded_flag));
    tx_unpack_checker tx_unpack_checker_i (.pclk(pclk), .presetn(presetn),
        .link_valid(tx_link_if_i.link_valid), .link_ready(tx_link_if_i.link_ready),
        .link_data(tx_link_if_i.link_data), .mac_ready(mac_ready), .mac_valid(mac_valid),
        .mac_data(mac_data), .mac_last(mac_last), .cmd_store_valid(cmd_store_valid),
        .cmd_store_word(cmd_store_word), .pkt_done(pkt_done), .pkt_error(pkt_error),
        .error_clear(error_clear), .transmit_error_flag(transmit_error_flag),
        .buffer_loaded_flag(buffer_loaded_flag));

    // ----------------------------------------------------------------------
    // Clock, MAC stalls and output monitor
    // ----------------------------------------------------------------------
    initial begin
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // The MAC stalls one cycle in four so held bytes are exercised.
    always @(posedge pclk) begin
        cyc <= cyc + 2'h1;
        mac_ready <= (cyc != 2'h3);
        if (presetn && mac_valid === 1'b1 && mac_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("mac_extra", 0, 1);
            else begin
                chk("mac_byte", {23'h0, exp_q[0]}, {23'h0, mac_last, mac_data});
                void'(exp_q.pop_front());
            end
        end
        if (pkt_done === 1'b1) begin
            dones++;
            st <= {pkt_tag, pkt_add_crc, pkt_add_pad, pkt_error};
        end
        if (buffer_loaded_flag === 1'b1) n_ld++;
        if (cmd_store_valid === 1'b1) n_st++;
    end

    // ----------------------------------------------------------------------
    // Bus tasks and tests
    // ----------------------------------------------------------------------
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sends one buffer: skip words, payload with junk lanes, then filler to the alignment.
    task automatic send_buf(input logic [31:0] a, input logic [31:0] b, input logic [7:0] base);
        int lo, len, n, tot, m, i;
        logic [31:0] w;
        lo = a[17:16];
        len = a[10:0];
        n = (lo + len + 3) / 4;
        tot = a[20:18] + n;
        m = (a[25:24] == `ALIGN_16) ? 3 : (a[25:24] == `ALIGN_32) ? 7 : 0;
        apb(`REG_CMD_A, 1, a);
        apb(`REG_CMD_B, 1, b);
        apb(`REG_SEND, 1, 0);
        for (i = 0; i < a[20:18]; i++) apb(`REG_DATA, 1, 32'h5a5a_5a5a);
        for (i = 0; i < n * 4; i++) begin
            w[8 * (i % 4) +: 8] = (i >= lo && i < lo + len) ? 8'(base + i - lo) : 8'hee;
            if (i >= lo && i < lo + len) begin
                exp_q.push_back({a[12] && i == lo + len - 1, w[8 * (i % 4) +: 8]});
            end
            if (i % 4 == 3) apb(`REG_DATA, 1, w);
        end
        for (i = tot; i < ((tot + m) & ~m); i++) apb(`REG_DATA, 1, 32'ha5a5_a5a5);
        // Every link word: two command words, skipped DWORDs, payload and filler.
        words += 2 + ((tot + m) & ~m);
        stores += a[13] ? 2 : 1;
        loads += a[31];
    endtask

    task automatic wait_pkt(input int want, input logic [18:0] exp);
        int k;
        for (k = 0; k < 600 && (exp_q.size() != 0 || dones != want); k++) @(posedge pclk);
        // A packet that never closes is caught here rather than by a stale status.
        chk("pkt_count", want, dones);
        chk("bytes_left", 0, exp_q.size());
        @(posedge pclk);
        chk("packet_status", {13'h0, exp}, {13'h0, st});
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        test_done;
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(`REG_CMD_A, 1, 32'hffff_ffff);
        apb(`REG_CMD_A, 0, 0);
        chk("cmd_a_mask", 32'hffff_ffff & ~`A_RSVD_MASK, rd);
        apb(12'h100, 0, 0);
        chk("unmapped", 1, e);
        apb(`REG_CMD_A, 1, 32'h0000_0003);
        apb(`REG_SEND, 1, 0);
        chk("short_middle", 1, e);
        send_buf(32'h8000_3005, 32'h1234_0005, 8'h10);
        wait_pkt(1, {16'h1234, 3'b110});
        send_buf(32'h0107_3006, 32'h00ab_2006, 8'h20);
        wait_pkt(2, {16'h00ab, 3'b010});
        send_buf(32'h0202_2003, 32'h0c0d_100b, 8'h30);
        send_buf(32'h0003_0004, 32'h0, 8'h40);
        send_buf(32'h8001_1004, 32'h0, 8'h50);
        wait_pkt(3, {16'h0c0d, 3'b100});
        chk("err_clean", 0, transmit_error_flag);
        send_buf(32'h0000_3002, 32'h0077_0003, 8'h60);
        wait_pkt(4, {16'h0077, 3'b111});
        chk("err_set", 1, transmit_error_flag);
        error_clear <= 1'b1;
        @(posedge pclk);
        error_clear <= 1'b0;
        @(posedge pclk);
        chk("err_cleared", 0, transmit_error_flag);
        apb(`REG_STATUS, 0, 0);
        chk("words_sent", 32'(words) << 16, rd);
        chk("stores", stores, n_st);
        chk("loaded", loads, n_ld);
        test_done;
    end
endmodule // tx_buffer_command_unpacker_tb
